// ### common/apr_pkg.sv
package apr_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_OP_CTRL = 8'h02;
    localparam logic [7:0] IDX_TYA     = 8'h05;
    localparam logic [7:0] IDX_AUX     = 8'h09;
    localparam logic [7:0] IDX_RX1     = 8'h0A;
    localparam logic [7:0] IDX_RX3     = 8'h0C;
    localparam logic [7:0] IDX_MODE    = 8'h03;
    localparam logic [7:0] IDX_RATE    = 8'h04;
    localparam logic [7:0] IDX_CMD     = 8'h20;
    localparam logic [7:0] IDX_ADC     = 8'h21;
    localparam logic [7:0] IDX_STATUS  = 8'h22;

    localparam logic [7:0] ADDR_OP_CTRL = 8'(IDX_OP_CTRL * 4);
    localparam logic [7:0] ADDR_TYA     = 8'(IDX_TYA * 4);
    localparam logic [7:0] ADDR_AUX     = 8'(IDX_AUX * 4);
    localparam logic [7:0] ADDR_RX1     = 8'(IDX_RX1 * 4);
    localparam logic [7:0] ADDR_RX3     = 8'(IDX_RX3 * 4);
    localparam logic [7:0] ADDR_MODE    = 8'(IDX_MODE * 4);
    localparam logic [7:0] ADDR_RATE    = 8'(IDX_RATE * 4);
    localparam logic [7:0] ADDR_CMD     = 8'(IDX_CMD * 4);
    localparam logic [7:0] ADDR_ADC     = 8'(IDX_ADC * 4);
    localparam logic [7:0] ADDR_STATUS  = 8'(IDX_STATUS * 4);

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_EN       = 7;
    localparam int BIT_RX_EN    = 6;
    localparam int BIT_RX_CHN   = 5;
    localparam int BIT_TX_EN    = 3;
    localparam int BIT_F0       = 5;
    localparam int BIT_TX_MOD   = 5;
    localparam int BIT_FD       = 4;
    localparam int BIT_DEMOD_CH = 7;
    localparam int BIT_AMD_SEL  = 6;
    localparam int FILT_LSB     = 0;
    localparam int BIT_LIM      = 1;
    localparam int BIT_RG       = 0;
    localparam int MODE_TGT_BIT = 7;
    localparam int MODE_OM_LSB  = 3;
    localparam int TXR_LSB      = 4;
    localparam int RXR_LSB      = 0;

    // ------------------------------------------------------------
    // Mode, rate and command codes
    // ------------------------------------------------------------
    localparam logic [3:0] OM_TYPE_A  = 4'h1;
    localparam logic [3:0] OM_TYPE_B  = 4'h2;
    localparam logic [3:0] OM_SUBC    = 4'h3;
    localparam logic [3:0] OM_PSK     = 4'h4;
    localparam logic [3:0] OM_ACTIVE  = 4'h5;
    localparam logic [3:0] RATE_106   = 4'h0;
    localparam logic [3:0] RATE_212   = 4'h1;
    localparam logic [3:0] RATE_424   = 4'h2;
    localparam logic [3:0] RATE_848   = 4'h3;
    localparam logic [7:0] CMD_PRESET = 8'h01;
    localparam logic [7:0] CMD_MASK   = 8'h02;
    localparam logic [7:0] CMD_UNMASK = 8'h03;
    localparam logic [7:0] CMD_MEAS   = 8'h04;

    // Low-pass and zero-setting presets {lp[2:0], zero[2:0]}
    localparam logic [5:0] FILT_ACTIVE = 6'h24;
    localparam logic [5:0] FILT_LOW    = 6'h08;
    localparam logic [5:0] FILT_HIGH   = 6'h13;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OP_CTRL  = 8'h00;
    localparam logic       RST_UNMASKED = 1'b1;
    localparam int CLK_MHZ       = 100;
    localparam int MEAS_MAX_US   = 25;
    localparam int MEAS_MAX_CYC  = MEAS_MAX_US * CLK_MHZ;
    localparam int AMP_LSB_UVPP  = 13020;
    localparam int DET_GAIN_X10  = 6;

    typedef enum logic [0:0] {APR_IDLE, APR_MEAS} apr_state_t;

endpackage

// ### hdl/apr_sync.sv
`timescale 1ns/100ps
module apr_sync (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Asynchronous level in, filtered level out
    input  wire logic d_in,
    output logic      q_out
);
    import apr_pkg::*;

    typedef struct packed {
        logic [2:0] sh;
        logic       q;
    } apr_sync_st_t;

    apr_sync_st_t r_reg;
    apr_sync_st_t r_next;

    // Level changes once the second and third stage agree
    always_comb begin
        r_next    = r_reg;
        r_next.sh = {r_reg.sh[1:0], d_in};
        if (r_reg.sh[1] == r_reg.sh[2]) begin
            r_next.q = r_reg.sh[2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q_out = r_reg.q;
endmodule

// ### hdl/apr_timer.sv
`timescale 1ns/100ps
module apr_timer #(
    parameter int CYC = 2500,
    parameter int W   = 12
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // Control
    input  wire logic start_in,
    input  wire logic stop_in,
    // Expiry, high in the last cycle of the window
    output logic      expired_out
);
    import apr_pkg::*;

    typedef struct packed {
        logic         run;
        logic [W-1:0] cnt;
    } apr_tmr_st_t;

    apr_tmr_st_t r_reg;
    apr_tmr_st_t r_next;

    always_comb begin
        r_next = r_reg;
        if (start_in) begin
            r_next.run = 1'b1;
            r_next.cnt = W'(CYC - 2);
        end else if (stop_in || expired_out) begin
            r_next.run = 1'b0;
        end else if (r_reg.run) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign expired_out = r_reg.run && (r_reg.cnt == '0);
endmodule

// ### hdl/apr_core.sv
// Summary of operation
// - Preset loads bits from mode and rate
// - Active peer mode sets single channel
// - Target or active initiator clears transmitter
// - Active peer mode sets start byte insert
// - Modulation type from mode and tx rate
// - Peer field detector only in active mode
// - Active peer mode selects amplitude channel
// - Peak detector up to fc/16, else mixer
// - Filter and zero bits from mode, rate
// - Clipping and gain reduction in active mode
// - Mask forces receive active low
// - Unmask drives receive active high
// - Unmask resets running mask timer
// - Mask commands need receiver enable
// - Mask commands chain, raise no completion
// - Measure routes amplitude detector to converter
// - Converter step is 13.02 mVpp
// - Measurement finishes within 25 us
// - Measure needs enable and stable oscillator
// - Measure raises completion, no chaining
// - Field commands set transmitter enable
`timescale 1ns/100ps
module apr_core (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Oscillator and converter
    input  wire logic        osc_stable_in,
    input  wire logic        adc_done_in,
    input  wire logic [7:0]  adc_data_in,
    output logic             adc_start_out,
    output logic             adc_mux_amp_out,
    output logic             adc_absolute_out,
    output logic             amp_det_en_out,
    output logic             tx_drive_out,
    // Receive gating
    input  wire logic        mask_timer_running_in,
    output logic             mask_timer_reset_out,
    output logic             rx_on_out,
    output logic             rx_framing_en_out,
    // Field commands and completion
    input  wire logic        field_on_ok_in,
    output logic             cmd_done_irq_out
);
    import apr_pkg::*;

    typedef struct packed {
        logic [7:0]  op_ctrl;
        logic [7:0]  tya;
        logic [7:0]  aux;
        logic [7:0]  rx1;
        logic [7:0]  rx3;
        logic [7:0]  mode;
        logic [7:0]  rate;
        logic [7:0]  adc;
        logic [31:0] rdata;
        logic        unmasked;
        logic        adc_go;
        logic        done;
        logic        tmr_rst;
        logic [11:0] age;
        apr_state_t  state;
    } apr_core_st_t;

    localparam apr_core_st_t RST_ST = '{
        op_ctrl:  RST_OP_CTRL,
        unmasked: RST_UNMASKED,
        state:    APR_IDLE,
        default:  '0
    };

    apr_core_st_t r_reg;
    apr_core_st_t r_next;

    logic        osc_ok;
    logic        tmr_exp;
    logic        wr;
    logic        hit;
    logic [7:0]  rd_byte;
    logic        cmd_go;
    logic [7:0]  cmd;
    logic        busy;
    logic [3:0]  om;
    logic [3:0]  txr;
    logic [3:0]  rxr;
    logic        active;
    logic        target;
    logic        acc_preset;
    logic        acc_mask;
    logic        acc_unmask;
    logic        acc_meas;

    // ------------------------------------------------------------
    // Oscillator-stable synchroniser and measurement window
    // ------------------------------------------------------------
    apr_sync u_osc_sync (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .d_in     (osc_stable_in),
        .q_out    (osc_ok)
    );

    apr_timer #(
        .CYC (MEAS_MAX_CYC),
        .W   (12)
    ) u_meas_tmr (
        .clock_in    (clock_in),
        .srst_in     (srst_in),
        .start_in    (acc_meas),
        .stop_in     (busy && adc_done_in),
        .expired_out (tmr_exp)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign busy   = (r_reg.state == APR_MEAS);
    assign om     = r_reg.mode[MODE_OM_LSB +: 4];
    assign target = r_reg.mode[MODE_TGT_BIT];
    assign txr    = r_reg.rate[TXR_LSB +: 4];
    assign rxr    = r_reg.rate[RXR_LSB +: 4];
    assign active = (om == OM_ACTIVE);
    assign wr     = psel_in && penable_in && pwrite_in;
    assign cmd_go = wr && (paddr_in == ADDR_CMD);
    assign cmd    = pwdata_in[7:0];

    // Measurement owns the front end, so no command is taken meanwhile
    assign acc_preset = cmd_go && !busy && (cmd == CMD_PRESET);
    assign acc_mask   = cmd_go && !busy && (cmd == CMD_MASK)
                        && r_reg.op_ctrl[BIT_RX_EN];
    assign acc_unmask = cmd_go && !busy && (cmd == CMD_UNMASK)
                        && r_reg.op_ctrl[BIT_RX_EN];
    assign acc_meas   = cmd_go && !busy && (cmd == CMD_MEAS)
                        && r_reg.op_ctrl[BIT_EN] && osc_ok;

    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (paddr_in)
            ADDR_OP_CTRL: rd_byte = r_reg.op_ctrl;
            ADDR_TYA:     rd_byte = r_reg.tya;
            ADDR_AUX:     rd_byte = r_reg.aux;
            ADDR_RX1:     rd_byte = r_reg.rx1;
            ADDR_RX3:     rd_byte = r_reg.rx3;
            ADDR_MODE:    rd_byte = r_reg.mode;
            ADDR_RATE:    rd_byte = r_reg.rate;
            ADDR_CMD:     rd_byte = 8'h00;
            ADDR_ADC:     rd_byte = r_reg.adc;
            ADDR_STATUS:  rd_byte = {5'h00, r_reg.unmasked, osc_ok, busy};
            default:      hit     = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next         = r_reg;
        r_next.adc_go  = 1'b0;
        r_next.done    = 1'b0;
        r_next.tmr_rst = 1'b0;
        // Cycles spent measuring, watched by the window check
        r_next.age     = busy ? r_reg.age + 12'h001 : 12'h000;
        if (psel_in && !penable_in) begin
            r_next.rdata = {24'h000000, rd_byte};
        end
        if (wr) begin
            case (paddr_in)
                ADDR_OP_CTRL: r_next.op_ctrl = pwdata_in[7:0];
                ADDR_TYA:     r_next.tya     = pwdata_in[7:0];
                ADDR_AUX:     r_next.aux     = pwdata_in[7:0];
                ADDR_RX1:     r_next.rx1     = pwdata_in[7:0];
                ADDR_RX3:     r_next.rx3     = pwdata_in[7:0];
                ADDR_MODE:    r_next.mode    = pwdata_in[7:0];
                ADDR_RATE:    r_next.rate    = pwdata_in[7:0];
                default:      r_next.rate    = r_next.rate;
            endcase
        end

        if (acc_preset) begin
            if (active) begin
                r_next.op_ctrl[BIT_RX_CHN] = 1'b1;
                r_next.tya[BIT_F0]         = 1'b1;
                r_next.rx1[BIT_DEMOD_CH]   = 1'b0;
            end
            if (target || active) begin
                r_next.op_ctrl[BIT_TX_EN] = 1'b0;
            end
            if (om == OM_TYPE_A || (active && txr == RATE_106)) begin
                r_next.aux[BIT_TX_MOD] = 1'b0;
            end else if (om == OM_TYPE_B || (active
                         && (txr == RATE_212 || txr == RATE_424))) begin
                r_next.aux[BIT_TX_MOD] = 1'b1;
            end
            r_next.aux[BIT_FD]       = active;
            r_next.rx1[BIT_AMD_SEL]  = (rxr > RATE_848);
            if (active) begin
                r_next.rx1[FILT_LSB +: 6] = FILT_ACTIVE;
            end else if (rxr <= RATE_212) begin
                r_next.rx1[FILT_LSB +: 6] = FILT_LOW;
            end else begin
                r_next.rx1[FILT_LSB +: 6] = FILT_HIGH;
            end
            r_next.rx3[BIT_LIM] = active;
            r_next.rx3[BIT_RG]  = active;
        end

        // Both gating commands chain freely and never complete loudly
        if (acc_mask) begin
            r_next.unmasked = 1'b0;
        end
        if (acc_unmask) begin
            r_next.unmasked = 1'b1;
            r_next.tmr_rst  = mask_timer_running_in;
        end

        case (r_reg.state)
            APR_IDLE: begin
                if (acc_meas) begin
                    r_next.state  = APR_MEAS;
                    r_next.adc_go = 1'b1;
                end
            end
            APR_MEAS: begin
                if (adc_done_in) begin
                    // One step is 13.02 mVpp with detector gain 0.6
                    r_next.adc   = adc_data_in;
                    r_next.done  = 1'b1;
                    r_next.state = APR_IDLE;
                end else if (tmr_exp) begin
                    r_next.done  = 1'b1;
                    r_next.state = APR_IDLE;
                end
            end
            default: r_next.state = APR_IDLE;
        endcase

        // Field-on success wins over a software clear in the same cycle
        if (field_on_ok_in) begin
            r_next.op_ctrl[BIT_TX_EN] = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_reg <= RST_ST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_out           = r_reg.rdata;
    assign pready_out           = 1'b1;
    assign pslverr_out          = psel_in && penable_in && !hit;
    assign adc_start_out        = r_reg.adc_go;
    assign adc_mux_amp_out      = busy;
    assign adc_absolute_out     = busy;
    assign amp_det_en_out       = busy;
    assign tx_drive_out         = busy || r_reg.op_ctrl[BIT_TX_EN];
    assign mask_timer_reset_out = r_reg.tmr_rst;
    assign rx_on_out = r_reg.unmasked && r_reg.op_ctrl[BIT_RX_EN];
    assign rx_framing_en_out    = r_reg.unmasked;
    assign cmd_done_irq_out     = r_reg.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_meas_go;
        acc_meas ##1 (busy && amp_det_en_out && tx_drive_out);
    endsequence

    property p_meas_route;
        @(posedge clock_in) disable iff (srst_in)
        acc_meas |-> s_meas_go;
    endproperty
    a_meas_route: assert property (p_meas_route)
        else $error("measurement did not route detector");

    property p_meas_bound;
        @(posedge clock_in) disable iff (srst_in)
        busy |=> (!busy && cmd_done_irq_out)
                 || (busy && r_reg.age < MEAS_MAX_CYC - 1);
    endproperty
    a_meas_bound: assert property (p_meas_bound)
        else $error("measurement exceeded its window");

    property p_done_cause;
        @(posedge clock_in) disable iff (srst_in)
        cmd_done_irq_out |-> $past(busy) && !busy;
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("completion without a measurement");

    property p_meas_refuse;
        @(posedge clock_in) disable iff (srst_in)
        (cmd_go && cmd == CMD_MEAS && !busy && !osc_ok) |=> !busy;
    endproperty
    a_meas_refuse: assert property (p_meas_refuse)
        else $error("measure taken with unstable oscillator");

    property p_mask;
        @(posedge clock_in) disable iff (srst_in)
        acc_mask |=> !rx_on_out && !rx_framing_en_out
                     && !cmd_done_irq_out;
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask left receiver active");

    property p_unmask;
        @(posedge clock_in) disable iff (srst_in)
        (acc_unmask && mask_timer_running_in) |=>
            rx_on_out && mask_timer_reset_out ##1 !mask_timer_reset_out;
    endproperty
    a_unmask: assert property (p_unmask)
        else $error("unmask did not reset the mask timer");

    property p_mask_refused;
        @(posedge clock_in) disable iff (srst_in)
        (cmd_go && !busy && cmd == CMD_MASK && !r_reg.op_ctrl[BIT_RX_EN])
            |=> $stable(rx_framing_en_out);
    endproperty
    a_mask_refused: assert property (p_mask_refused)
        else $error("mask taken with receiver disabled");

    property p_preset_fd;
        @(posedge clock_in) disable iff (srst_in)
        acc_preset |=> r_reg.aux[BIT_FD] == $past(active)
                       && r_reg.rx3[BIT_RG] == $past(active);
    endproperty
    a_preset_fd: assert property (p_preset_fd)
        else $error("preset detector or gain bit wrong");

    property p_preset_tx;
        @(posedge clock_in) disable iff (srst_in)
        (acc_preset && (target || active) && !field_on_ok_in)
            |=> !r_reg.op_ctrl[BIT_TX_EN];
    endproperty
    a_preset_tx: assert property (p_preset_tx)
        else $error("preset left transmitter enabled");

    property p_field_on;
        @(posedge clock_in) disable iff (srst_in)
        field_on_ok_in |=> r_reg.op_ctrl[BIT_TX_EN];
    endproperty
    a_field_on: assert property (p_field_on)
        else $error("field-on did not set transmitter enable");
endmodule

// ### bench/apr_adc_model.sv
`timescale 1ns/100ps
module apr_adc_model (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    // Converter control from the block
    input  wire logic       start_in,
    input  wire logic       amp_sel_in,
    input  wire logic       absolute_in,
    // Scenario settings
    input  wire logic [7:0] delay_in,
    input  wire logic [7:0] value_in,
    // Result
    output logic            done_out,
    output logic [7:0]      data_out
);
    logic [7:0] cnt_reg;
    logic       busy_reg;

    // Data toggles outside the done cycle so stale values never match
    always_ff @(posedge clock_in) begin
        done_out <= 1'b0;
        data_out <= ~data_out;
        if (srst_in) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 8'h00;
            data_out <= 8'h00;
        end else if (start_in) begin
            busy_reg <= 1'b1;
            cnt_reg  <= delay_in;
        end else if (busy_reg && cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else if (busy_reg && amp_sel_in && absolute_in) begin
            busy_reg <= 1'b0;
            done_out <= 1'b1;
            data_out <= value_in;
        end
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import apr_pkg::*;
    logic        clock_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out, pslverr_out;
    logic        osc_stable_in = 1'b1;
    logic        adc_done_in, adc_start_out, adc_mux_amp_out;
    logic [7:0]  adc_data_in;
    logic        adc_absolute_out, amp_det_en_out, tx_drive_out;
    logic        mask_timer_running_in = 1'b0;
    logic        mask_timer_reset_out, rx_on_out, rx_framing_en_out;
    logic        field_on_ok_in = 1'b0;
    logic        cmd_done_irq_out;
    logic [7:0]  lfsr = 8'h4B;
    logic [7:0]  p, dly = 8'h00, val = 8'h00;
    logic [3:0]  om, tx, rx;
    logic        tgt, err_v;
    logic [39:0] e;
    logic [31:0] rd_v;
    int          fails = 0, samples_checked = 0, i, k, n;
    localparam logic [7:0] RA [5] = '{ADDR_OP_CTRL, ADDR_TYA, ADDR_AUX,
                                      ADDR_RX1, ADDR_RX3};

    always #5 clock_in = ~clock_in;

    apr_core apr_core_inst (.clock_in(clock_in), .srst_in(srst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .osc_stable_in(osc_stable_in), .adc_done_in(adc_done_in),
        .adc_data_in(adc_data_in), .adc_start_out(adc_start_out),
        .adc_mux_amp_out(adc_mux_amp_out),
        .adc_absolute_out(adc_absolute_out),
        .amp_det_en_out(amp_det_en_out), .tx_drive_out(tx_drive_out),
        .mask_timer_running_in(mask_timer_running_in),
        .mask_timer_reset_out(mask_timer_reset_out), .rx_on_out(rx_on_out),
        .rx_framing_en_out(rx_framing_en_out),
        .field_on_ok_in(field_on_ok_in),
        .cmd_done_irq_out(cmd_done_irq_out));

    apr_adc_model apr_adc_model_inst (.clock_in(clock_in),
        .srst_in(srst_in), .start_in(adc_start_out),
        .amp_sel_in(adc_mux_amp_out), .absolute_in(adc_absolute_out),
        .delay_in(dly), .value_in(val), .done_out(adc_done_in),
        .data_out(adc_data_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [39:0] exp_preset(input logic [7:0] q,
        input logic t, input logic [3:0] m, input logic [3:0] txr,
        input logic [3:0] rxr);
        logic [7:0] op, ty, ax, r1, r3;
        logic       act;
        act = (m == OM_ACTIVE);
        {op, ty, ax, r1, r3} = {5{q}};
        if (act) op[5] = 1'b1;
        if (t || act) op[3] = 1'b0;
        if (act) ty[5] = 1'b1;
        if (m == OM_TYPE_A || (act && txr == RATE_106)) ax[5] = 1'b0;
        else if (m == OM_TYPE_B || act) ax[5] = 1'b1;
        ax[4] = act;
        if (act) r1[7] = 1'b0;
        r1[6] = (rxr > 4'h3);
        r1[5:0] = act ? FILT_ACTIVE
                : (rxr <= RATE_212 ? FILT_LOW : FILT_HIGH);
        r3[1:0] = {act, act};
        return {op, ty, ax, r1, r3};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        rd_v = prdata_out;
        err_v = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        `CHK("framing_rst", 1'b1, rx_framing_en_out)
        apb(1'b0, ADDR_OP_CTRL, 32'h0);
        `CHK("op_ctrl_rst", RST_OP_CTRL, rd_v[7:0])
        apb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped_err", 1'b1, err_v)
        `CHK("unmapped_rd", 32'h0, rd_v)
        for (i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            p = lfsr;
            om = (i % 3 == 0) ? OM_TYPE_A
               : (i % 3 == 1) ? OM_TYPE_B : OM_ACTIVE;
            tgt = (i >= 6);
            lfsr = lfsr_next(lfsr);
            tx = 4'(lfsr[3:0] % 3);
            rx = 4'(lfsr[7:4] % 4);
            for (k = 0; k < 5; k++) apb(1'b1, RA[k], {24'h0, p});
            apb(1'b1, ADDR_MODE, {24'h0, tgt, om, 3'b000});
            apb(1'b1, ADDR_RATE, {24'h0, tx, rx});
            apb(1'b1, ADDR_CMD, {24'h0, CMD_PRESET});
            #1;
            `CHK("preset_irq", 1'b0, cmd_done_irq_out)
            e = exp_preset(p, tgt, om, tx, rx);
            for (k = 0; k < 5; k++) begin
                apb(1'b0, RA[k], 32'h0);
                `CHK("preset_reg", e[39-8*k -: 8],
                     rd_v[7:0])
            end
        end
        apb(1'b1, ADDR_OP_CTRL, 32'hC0);
        apb(1'b1, ADDR_CMD, {24'h0, CMD_MASK});
        #1;
        `CHK("mask_rx_on", 1'b0, rx_on_out)
        `CHK("mask_framing", 1'b0, rx_framing_en_out)
        `CHK("mask_irq", 1'b0, cmd_done_irq_out)
        mask_timer_running_in <= 1'b1;
        apb(1'b1, ADDR_CMD, {24'h0, CMD_UNMASK});
        #1;
        `CHK("unmask_rx_on", 1'b1, rx_on_out)
        `CHK("unmask_framing", 1'b1, rx_framing_en_out)
        `CHK("timer_reset", 1'b1, mask_timer_reset_out)
        `CHK("unmask_irq", 1'b0, cmd_done_irq_out)
        @(posedge clock_in);
        #1;
        `CHK("timer_reset_end", 1'b0, mask_timer_reset_out)
        mask_timer_running_in <= 1'b0;
        apb(1'b1, ADDR_OP_CTRL, 32'h80);
        apb(1'b1, ADDR_CMD, {24'h0, CMD_MASK});
        #1;
        `CHK("mask_refused", 1'b1, rx_framing_en_out)
        osc_stable_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        apb(1'b1, ADDR_CMD, {24'h0, CMD_MEAS});
        #1;
        `CHK("meas_no_osc", 1'b0, adc_start_out)
        osc_stable_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        apb(1'b1, ADDR_OP_CTRL, 32'h0);
        apb(1'b1, ADDR_CMD, {24'h0, CMD_MEAS});
        #1;
        `CHK("meas_no_en", 1'b0, adc_start_out)
        for (i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            dly = lfsr;
            lfsr = lfsr_next(lfsr);
            val = lfsr;
            apb(1'b1, ADDR_OP_CTRL, 32'h80);
            apb(1'b1, ADDR_CMD, {24'h0, CMD_MEAS});
            #1;
            `CHK("meas_outs", 5'h1F, {adc_start_out, amp_det_en_out,
                 adc_mux_amp_out, adc_absolute_out, tx_drive_out})
            n = 0;
            while (cmd_done_irq_out !== 1'b1 && n < 3000) begin
                @(posedge clock_in);
                #1;
                n++;
            end
            `CHK("meas_time", 1'b1, n < MEAS_MAX_CYC)
            `CHK("meas_irq", 1'b1, cmd_done_irq_out)
            @(posedge clock_in);
            #1;
            `CHK("meas_end", 2'b00, {cmd_done_irq_out, amp_det_en_out})
            apb(1'b0, ADDR_ADC, 32'h0);
            `CHK("adc_result", val, rd_v[7:0])
        end
        @(posedge clock_in);
        field_on_ok_in <= 1'b1;
        @(posedge clock_in);
        field_on_ok_in <= 1'b0;
        apb(1'b0, ADDR_OP_CTRL, 32'h0);
        `CHK("field_tx_en", 1'b1, rd_v[BIT_TX_EN])
        end_sim();
    end
endmodule
